/* core/lps_regs.sv */
// Register bank of the light and proximity sensor with its serial target port.
// Contract
// - Twelve byte registers, all readable or writable over the two-wire bus.
// - Address zero is reserved; it reads as zero and ignores writes.
// - Proximity-on bit starts continuous conversions; first result 0.54ms later.
// - Pause field sets idle time between LED pulses, 0ms up to 800ms.
// - Sink strength bit picks 110mA when clear, 220mA when set.
// - Light-on bit runs light conversions with a fresh result every 100ms.
// - Span bit picks low-lux range when clear, high-lux range when set.
// - Spectrum bit picks visible data when clear, infrared data when set.
// - Mode controls at 0x1-0x2, thresholds at 0x3-0x7 with split 12-bit limits.
// - Result registers 0x08-0x0A are read-only; upper nibble of 0x0A reads zero.
// - Persistence fields need 1, 4, 8 or 16 tripping conversions to flag.
// - Event flags stay set until the host writes zero to them.
// - Combine bit drives the low-active event pin from OR or AND of flags.
// - Only the fixed target address 1000100 is answered.
`timescale 1ns/10ps
`default_nettype none
`include "lps_defs.svh"
module lps_regs #(
  parameter int PROX_FIRST_CYCLES   = `LPS_PROX_FIRST_CYC,
  parameter int PAUSE_UNIT_CYCLES   = `LPS_PAUSE_UNIT_CYC,
  parameter int LIGHT_PERIOD_CYCLES = `LPS_LIGHT_CYC
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 link_clk,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  input  wire lps_pkg::lps_byte_t   prox_sample,
  input  wire lps_pkg::lps_word12_t light_sample,
  output logic                      led_sink_output,
  output logic                      led_sink_strength,
  output logic                      light_sense_on,
  output logic                      light_span_select,
  output logic                      light_spectrum_select,
  output logic                      event_n_o,
  output logic                      event_n_oe
);
  import lps_pkg::*;

  // Link domain: pin synchronisers, target state machine, request toggle.
  logic         scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, lrst_m, lrst_q, ack_m, ack_s;
  lps_link_st_t lst_q, lst_d;
  logic [3:0]   bits_q, bits_d;
  lps_byte_t    shreg_q, shreg_d, ptr_q, ptr_d, req_addr_q, req_addr_d, req_data_q, req_data_d;
  logic         rw_q, rw_d, first_q, first_d, req_q, req_d, req_wr_q, req_wr_d;
  logic         issued_q, issued_d, sda_oe_q, sda_oe_d;
  logic         scl_rise, scl_fall, bus_start, bus_stop;
  // Reference domain.
  logic         rq_m, rq_s, rq_p, ack_q, ack_d, op;
  lps_byte_t    rd_data_q, rd_data_d, setup_q, setup_d, evt_q, evt_d;
  lps_byte_t    plo_q, plo_d, phi_q, phi_d, llo_q, llo_d, lmix_q, lmix_d, lhi_q, lhi_d;
  lps_byte_t    pres_q, pres_d, test_a_q, test_a_d, test_b_q, test_b_d;
  lps_word12_t  lres_q, lres_d, llim, hlim;
  lps_prox_st_t pst_q, pst_d;
  logic [31:0]  ptim_q, ptim_d, ltim_q, ltim_d, pause_cyc;
  logic [4:0]   phits_q, phits_d, lhits_q, lhits_d, pneed, lneed;
  logic         evt_oe_q, evt_oe_d, pcap, lcap, ptrip, ltrip, pset, lset, wr_op;
  logic         clr_prox, clr_light;

  always_ff @(posedge link_clk)
  begin
    scl_m  <= scl_i;
    scl_s  <= scl_m;
    scl_p  <= scl_s;
    sda_m  <= sda_i;
    sda_s  <= sda_m;
    sda_p  <= sda_s;
    lrst_m <= reset;
    lrst_q <= lrst_m;
    ack_m  <= ack_q;
    ack_s  <= ack_m;
  end

  assign scl_rise  = scl_s & ~scl_p;
  assign scl_fall  = ~scl_s & scl_p;
  assign bus_start = scl_s & scl_p & sda_p & ~sda_s;
  assign bus_stop  = scl_s & scl_p & ~sda_p & sda_s;

  always_comb
  begin
    lst_d = lst_q;
    bits_d = bits_q;
    shreg_d = shreg_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    first_d = first_q;
    req_d = req_q;
    req_wr_d = req_wr_q;
    req_addr_d = req_addr_q;
    req_data_d = req_data_q;
    issued_d = issued_q;
    sda_oe_d = sda_oe_q;
    case (lst_q)
      LK_IDLE: ;
      LK_ADDR, LK_RX:
        if (scl_rise)
        begin
          shreg_d = {shreg_q[6:0], sda_s};
          bits_d = bits_q + 4'h1;
        end
        else if (scl_fall && bits_q == 4'h8)
        begin
          bits_d = 4'h0;
          if (lst_q == LK_ADDR)
          begin
            if (shreg_q[7:1] == `LPS_TARGET_ADDR)
            begin
              lst_d = LK_ACK;
              sda_oe_d = 1'b1;
              rw_d = shreg_q[0];
              first_d = 1'b1;
            end
            else
              lst_d = LK_IDLE;
          end
          else
          begin
            lst_d = LK_ACK;
            sda_oe_d = 1'b1;
            first_d = 1'b0;
            if (first_q)
              ptr_d = shreg_q;
            else
            begin
              req_d = ~req_q;
              req_wr_d = 1'b1;
              req_addr_d = ptr_q;
              req_data_d = shreg_q;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
      LK_ACK:
        if (scl_fall)
        begin
          sda_oe_d = 1'b0;
          issued_d = 1'b0;
          lst_d = rw_q ? LK_LOAD : LK_RX;
        end
      LK_LOAD:
        if (ack_s == req_q)
        begin
          if (!issued_q)
          begin
            req_d = ~req_q;
            req_wr_d = 1'b0;
            req_addr_d = ptr_q;
            issued_d = 1'b1;
          end
          else
          begin
            shreg_d = rd_data_q;
            sda_oe_d = ~rd_data_q[7];
            bits_d = 4'h0;
            ptr_d = ptr_q + 8'h01;
            lst_d = LK_TX;
          end
        end
      LK_TX:
        if (scl_fall)
        begin
          if (bits_q == 4'h7)
          begin
            sda_oe_d = 1'b0;
            lst_d = LK_RACK;
          end
          else
          begin
            bits_d = bits_q + 4'h1;
            shreg_d = {shreg_q[6:0], 1'b0};
            sda_oe_d = ~shreg_q[6];
          end
        end
      LK_RACK:
        if (scl_rise && sda_s)
          lst_d = LK_IDLE;
        else if (scl_fall)
        begin
          issued_d = 1'b0;
          lst_d = LK_LOAD;
        end
      default: lst_d = LK_IDLE;
    endcase
    if (bus_stop)
    begin
      lst_d = LK_IDLE;
      sda_oe_d = 1'b0;
    end
    if (bus_start)
    begin
      lst_d = LK_ADDR;
      bits_d = 4'h0;
      sda_oe_d = 1'b0;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
    begin
      lst_q <= LK_IDLE;
      bits_q <= 4'h0;
      shreg_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      req_q <= 1'b0;
      req_wr_q <= 1'b0;
      req_addr_q <= 8'h00;
      req_data_q <= 8'h00;
      issued_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      lst_q <= lst_d;
      bits_q <= bits_d;
      shreg_q <= shreg_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      first_q <= first_d;
      req_q <= req_d;
      req_wr_q <= req_wr_d;
      req_addr_q <= req_addr_d;
      req_data_q <= req_data_d;
      issued_q <= issued_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_q;

  always_ff @(posedge ref_clk)
  begin
    rq_m <= req_q;
    rq_s <= rq_m;
    rq_p <= rq_s;
  end

  // Request fields are held stable by the link until the toggle is answered.
  assign op        = rq_s ^ rq_p;
  assign wr_op     = op & req_wr_q;
  assign clr_prox  = wr_op && req_addr_q == `LPS_OFS_EVT && !req_data_q[`LPS_EVT_PROX_FLAG];
  assign clr_light = wr_op && req_addr_q == `LPS_OFS_EVT && !req_data_q[`LPS_EVT_LIGHT_FLAG];
  assign llim      = {lmix_q[3:0], llo_q};
  assign hlim      = {lhi_q, lmix_q[7:4]};
  assign pcap      = pst_q == PX_CONV && ptim_q == 32'h0;
  assign lcap      = setup_q[`LPS_SET_LIGHT_ON] && ltim_q == 32'h0;
  assign ptrip     = prox_sample > phi_q;
  assign ltrip     = light_sample < llim || light_sample > hlim;
  assign pneed     = lps_persist_need(evt_q[`LPS_EVT_PROX_PMSB:`LPS_EVT_PROX_PLSB]);
  assign lneed     = lps_persist_need(evt_q[`LPS_EVT_LIGHT_PMSB:`LPS_EVT_LIGHT_PLSB]);
  assign pset      = pcap && ptrip && (phits_q + 5'h01) >= pneed;
  assign lset      = lcap && ltrip && (lhits_q + 5'h01) >= lneed;
  assign pause_cyc = 32'(lps_pause_units(setup_q[`LPS_SET_PAUSE_MSB:`LPS_SET_PAUSE_LSB]))
                     * 32'(PAUSE_UNIT_CYCLES);

  always_comb
  begin
    ack_d = ack_q;
    rd_data_d = rd_data_q;
    setup_d = setup_q;
    evt_d = evt_q;
    plo_d = plo_q;
    phi_d = phi_q;
    llo_d = llo_q;
    lmix_d = lmix_q;
    lhi_d = lhi_q;
    pres_d = pres_q;
    lres_d = lres_q;
    test_a_d = test_a_q;
    test_b_d = test_b_q;
    pst_d = pst_q;
    ptim_d = ptim_q;
    ltim_d = ltim_q;
    phits_d = phits_q;
    lhits_d = lhits_q;
    if (op)
    begin
      ack_d = rq_s;
      if (req_wr_q)
        case (req_addr_q)
          `LPS_OFS_SETUP:  setup_d = req_data_q;
          `LPS_OFS_EVT:    evt_d = {evt_q[7], req_data_q[6:4], evt_q[3], req_data_q[2:0]};
          `LPS_OFS_PLO:    plo_d = req_data_q;
          `LPS_OFS_PHI:    phi_d = req_data_q;
          `LPS_OFS_LLO:    llo_d = req_data_q;
          `LPS_OFS_LMIX:   lmix_d = req_data_q;
          `LPS_OFS_LHI:    lhi_d = req_data_q;
          `LPS_OFS_TEST_A: test_a_d = req_data_q;
          `LPS_OFS_TEST_B: test_b_d = req_data_q;
          default: ;
        endcase
      else
        case (req_addr_q)
          `LPS_OFS_SETUP:   rd_data_d = setup_q;
          `LPS_OFS_EVT:     rd_data_d = evt_q;
          `LPS_OFS_PLO:     rd_data_d = plo_q;
          `LPS_OFS_PHI:     rd_data_d = phi_q;
          `LPS_OFS_LLO:     rd_data_d = llo_q;
          `LPS_OFS_LMIX:    rd_data_d = lmix_q;
          `LPS_OFS_LHI:     rd_data_d = lhi_q;
          `LPS_OFS_PRES:    rd_data_d = pres_q;
          `LPS_OFS_LRES_LO: rd_data_d = lres_q[7:0];
          `LPS_OFS_LRES_HI: rd_data_d = {4'h0, lres_q[11:8]};
          `LPS_OFS_TEST_A:  rd_data_d = test_a_q;
          `LPS_OFS_TEST_B:  rd_data_d = test_b_q;
          default:          rd_data_d = 8'h00;
        endcase
    end
    case (pst_q)
      PX_IDLE:
        if (setup_q[`LPS_SET_PROX_ON])
        begin
          pst_d = PX_CONV;
          ptim_d = 32'(PROX_FIRST_CYCLES - 1);
        end
      PX_CONV:
        if (ptim_q != 32'h0)
          ptim_d = ptim_q - 32'h1;
        else
        begin
          pres_d = prox_sample;
          if (pause_cyc == 32'h0)
            ptim_d = 32'(PROX_FIRST_CYCLES - 1);
          else
          begin
            pst_d = PX_PAUSE;
            ptim_d = pause_cyc - 32'h1;
          end
        end
      PX_PAUSE:
        if (ptim_q != 32'h0)
          ptim_d = ptim_q - 32'h1;
        else
        begin
          pst_d = PX_CONV;
          ptim_d = 32'(PROX_FIRST_CYCLES - 1);
        end
      default: pst_d = PX_IDLE;
    endcase
    if (!setup_q[`LPS_SET_PROX_ON])
      pst_d = PX_IDLE;
    if (!setup_q[`LPS_SET_LIGHT_ON] || lcap)
      ltim_d = 32'(LIGHT_PERIOD_CYCLES - 1);
    else
      ltim_d = ltim_q - 32'h1;
    if (lcap)
      lres_d = light_sample;
    if (pcap)
      phits_d = !ptrip ? 5'h00 : (phits_q == 5'h10) ? phits_q : phits_q + 5'h01;
    if (lcap)
      lhits_d = !ltrip ? 5'h00 : (lhits_q == 5'h10) ? lhits_q : lhits_q + 5'h01;
    // A flag set in the same cycle as its clear stays set.
    evt_d[`LPS_EVT_PROX_FLAG] = (evt_q[`LPS_EVT_PROX_FLAG] & ~clr_prox) | pset;
    evt_d[`LPS_EVT_LIGHT_FLAG] = (evt_q[`LPS_EVT_LIGHT_FLAG] & ~clr_light) | lset;
    evt_oe_d = evt_q[`LPS_EVT_COMBINE] ? (evt_q[7] & evt_q[3]) : (evt_q[7] | evt_q[3]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ack_q <= 1'b0;
      rd_data_q <= 8'h00;
      setup_q <= `LPS_RST_SETUP;
      evt_q <= `LPS_RST_EVT;
      plo_q <= `LPS_RST_PLO;
      phi_q <= `LPS_RST_PHI;
      llo_q <= `LPS_RST_LLO;
      lmix_q <= `LPS_RST_LMIX;
      lhi_q <= `LPS_RST_LHI;
      pres_q <= `LPS_RST_RESULT;
      lres_q <= `LPS_RST_LRES;
      test_a_q <= `LPS_RST_TEST;
      test_b_q <= `LPS_RST_TEST;
      pst_q <= PX_IDLE;
      ptim_q <= 32'h0;
      ltim_q <= 32'h0;
      phits_q <= 5'h00;
      lhits_q <= 5'h00;
      evt_oe_q <= 1'b0;
    end
    else
    begin
      ack_q <= ack_d;
      rd_data_q <= rd_data_d;
      setup_q <= setup_d;
      evt_q <= evt_d;
      plo_q <= plo_d;
      phi_q <= phi_d;
      llo_q <= llo_d;
      lmix_q <= lmix_d;
      lhi_q <= lhi_d;
      pres_q <= pres_d;
      lres_q <= lres_d;
      test_a_q <= test_a_d;
      test_b_q <= test_b_d;
      pst_q <= pst_d;
      ptim_q <= ptim_d;
      ltim_q <= ltim_d;
      phits_q <= phits_d;
      lhits_q <= lhits_d;
      evt_oe_q <= evt_oe_d;
    end
  end

  assign led_sink_output       = pst_q == PX_CONV;
  assign led_sink_strength     = setup_q[`LPS_SET_SINK];
  assign light_sense_on        = setup_q[`LPS_SET_LIGHT_ON];
  assign light_span_select     = setup_q[`LPS_SET_SPAN];
  assign light_spectrum_select = setup_q[`LPS_SET_SPECTRUM];
  assign event_n_o             = 1'b0;
  assign event_n_oe            = evt_oe_q;

  sequence s_setup_write;
    wr_op && req_addr_q == `LPS_OFS_SETUP;
  endsequence
  sequence s_addr_done;
    lst_q == LK_ADDR && scl_fall && bits_q == 4'h8 && !bus_start && !bus_stop;
  endsequence
  property p_setup_write;
    @(posedge ref_clk) disable iff (reset) s_setup_write |=> setup_q == $past(req_data_q);
  endproperty
  a_setup_write: assert property (p_setup_write) else $error("setup write lost");
  property p_prox_start;
    @(posedge ref_clk) disable iff (reset)
      pst_q == PX_IDLE && setup_q[7] |=> pst_q == PX_CONV && ptim_q == PROX_FIRST_CYCLES - 1;
  endproperty
  a_prox_start: assert property (p_prox_start) else $error("prox start wrong");
  property p_prox_stop;
    @(posedge ref_clk) disable iff (reset) $fell(setup_q[7]) |=> !led_sink_output;
  endproperty
  a_prox_stop: assert property (p_prox_stop) else $error("prox did not stop");
  property p_pause_load;
    @(posedge ref_clk) disable iff (reset)
      pcap && setup_q[7] && pause_cyc != 32'h0 |=>
        pst_q == PX_PAUSE && ptim_q == $past(pause_cyc) - 32'h1;
  endproperty
  a_pause_load: assert property (p_pause_load) else $error("pause length wrong");
  property p_light_period;
    @(posedge ref_clk) disable iff (reset)
      lcap |=> ltim_q == LIGHT_PERIOD_CYCLES - 1 && lres_q == $past(light_sample);
  endproperty
  a_light_period: assert property (p_light_period) else $error("light period wrong");
  property p_result_ro;
    @(posedge ref_clk) disable iff (reset)
      wr_op && req_addr_q == `LPS_OFS_PRES && !pcap |=> $stable(pres_q);
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("result was written");
  property p_persist;
    @(posedge ref_clk) disable iff (reset)
      $rose(evt_q[7]) |-> $past(pcap && ptrip && (phits_q + 5'h01) >= pneed);
  endproperty
  a_persist: assert property (p_persist) else $error("flag set too early");
  property p_flag_hold;
    @(posedge ref_clk) disable iff (reset) evt_q[3] && !clr_light |=> evt_q[3];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("light flag dropped");
  property p_combine;
    @(posedge ref_clk) disable iff (reset)
      ##1 event_n_oe == ($past(evt_q[0]) ? $past(evt_q[7] & evt_q[3])
                                          : $past(evt_q[7] | evt_q[3]));
  endproperty
  a_combine: assert property (p_combine) else $error("event pin wrong");
  property p_addr_ack;
    @(posedge link_clk) disable iff (lrst_q)
      s_addr_done ##0 shreg_q[7:1] != `LPS_TARGET_ADDR |=> lst_q == LK_IDLE && !sda_oe_q;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("foreign address answered");
endmodule : lps_regs
`default_nettype wire

/* core/lps_defs.svh */
// Register offsets, field positions, reset values and timing counts of the sensor register bank.
`ifndef LPS_DEFS_SVH
`define LPS_DEFS_SVH
`define LPS_OFS_RSVD        8'h00
`define LPS_OFS_SETUP       8'h01
`define LPS_OFS_EVT         8'h02
`define LPS_OFS_PLO         8'h03
`define LPS_OFS_PHI         8'h04
`define LPS_OFS_LLO         8'h05
`define LPS_OFS_LMIX        8'h06
`define LPS_OFS_LHI         8'h07
`define LPS_OFS_PRES        8'h08
`define LPS_OFS_LRES_LO     8'h09
`define LPS_OFS_LRES_HI     8'h0A
`define LPS_OFS_TEST_A      8'h0E
`define LPS_OFS_TEST_B      8'h0F
`define LPS_RST_SETUP       8'h00
`define LPS_RST_EVT         8'h00
`define LPS_RST_PLO         8'h00
`define LPS_RST_PHI         8'hFF
`define LPS_RST_LLO         8'h00
`define LPS_RST_LMIX        8'hF0
`define LPS_RST_LHI         8'hFF
`define LPS_RST_RESULT      8'h00
`define LPS_RST_LRES        12'h000
`define LPS_RST_TEST        8'h00
`define LPS_SET_PROX_ON     7
`define LPS_SET_PAUSE_MSB   6
`define LPS_SET_PAUSE_LSB   4
`define LPS_SET_SINK        3
`define LPS_SET_LIGHT_ON    2
`define LPS_SET_SPAN        1
`define LPS_SET_SPECTRUM    0
`define LPS_EVT_PROX_FLAG   7
`define LPS_EVT_PROX_PMSB   6
`define LPS_EVT_PROX_PLSB   5
`define LPS_EVT_LIGHT_FLAG  3
`define LPS_EVT_LIGHT_PMSB  2
`define LPS_EVT_LIGHT_PLSB  1
`define LPS_EVT_COMBINE     0
`define LPS_TARGET_ADDR     7'h44
`define LPS_CLK_MHZ         40
`define LPS_PROX_FIRST_US   540
`define LPS_PAUSE_UNIT_US   12500
`define LPS_LIGHT_PERIOD_US 100000
`define LPS_PROX_FIRST_CYC  (`LPS_PROX_FIRST_US * `LPS_CLK_MHZ)
`define LPS_PAUSE_UNIT_CYC  (`LPS_PAUSE_UNIT_US * `LPS_CLK_MHZ)
`define LPS_LIGHT_CYC       (`LPS_LIGHT_PERIOD_US * `LPS_CLK_MHZ)
`endif

/* core/lps_pkg.sv */
// Types and decode functions of the sensor register bank.
package lps_pkg;
  typedef logic [7:0] lps_byte_t;
  typedef logic [11:0] lps_word12_t;
  typedef enum logic [6:0] {
    LK_IDLE = 7'b0000001, LK_ADDR = 7'b0000010, LK_RX = 7'b0000100, LK_ACK = 7'b0001000,
    LK_LOAD = 7'b0010000, LK_TX = 7'b0100000, LK_RACK = 7'b1000000
  } lps_link_st_t;
  typedef enum logic [2:0] {
    PX_IDLE = 3'b001, PX_CONV = 3'b010, PX_PAUSE = 3'b100
  } lps_prox_st_t;
  // Pause length in units of the shortest nonzero pause.
  function automatic logic [6:0] lps_pause_units(input logic [2:0] f);
    case (f)
      3'h7: lps_pause_units = 7'h00;
      3'h6: lps_pause_units = 7'h01;
      3'h5: lps_pause_units = 7'h04;
      3'h4: lps_pause_units = 7'h06;
      3'h3: lps_pause_units = 7'h08;
      3'h2: lps_pause_units = 7'h10;
      3'h1: lps_pause_units = 7'h20;
      default: lps_pause_units = 7'h40;
    endcase
  endfunction : lps_pause_units
  function automatic logic [4:0] lps_persist_need(input logic [1:0] f);
    case (f)
      2'h0: lps_persist_need = 5'h01;
      2'h1: lps_persist_need = 5'h04;
      2'h2: lps_persist_need = 5'h08;
      default: lps_persist_need = 5'h10;
    endcase
  endfunction : lps_persist_need
endpackage : lps_pkg

/* verif/lps_bus_master.sv */
// Two-wire bus master model that drives the sensor's serial port.
`timescale 1ns/10ps
`default_nettype none
module lps_bus_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Quarter bit time; low and high phases of the clock are 640 ns each.
  localparam int Q = 320;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Releases data, raises the clock, then pulls data low while the clock is high.
  task automatic start();
    sda_low = 1'b0;
    #(Q) scl = 1'b1;
    #(Q) sda_low = 1'b1;
    #(Q) scl = 1'b0;
    #(Q);
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    #(Q) scl = 1'b1;
    #(Q) sda_low = 1'b0;
    #(2 * Q);
  endtask : stop
  // Data changes only while the clock is low; the line is sampled mid-high.
  task automatic bitx(input logic b, output logic r);
    sda_low = ~b;
    #(Q) scl = 1'b1;
    #(Q) r = sda;
    #(Q) scl = 1'b0;
    #(Q);
  endtask : bitx
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask : rbyte
endmodule : lps_bus_master
`default_nettype wire

/* verif/test_lps_regs.sv */
// Self-checking bench for the sensor register bank.
`timescale 1ns/10ps
`default_nettype none
module test_lps_regs;
  import lps_pkg::*;
  localparam int PU = 10;
  logic        ref_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        reset = 1'b1;
  logic        scl, sda_low, sda_oe, led, ev_oe, strength, light_on, span, spectrum;
  wire         sda;
  lps_byte_t   prox_sample = 8'h00;
  lps_word12_t light_sample = 12'h000;
  lps_byte_t   rd[$];
  int          miscompares = 0;
  int          cmp_count = 0;
  logic [31:0] seed = 32'h0E38B446;
  // The bus has a pull-up, so a released line reads high.
  assign sda = ~(sda_oe | sda_low);
  always #12.5 ref_clk = ~ref_clk;
  always #16 link_clk = ~link_clk;
  lps_regs #(.PROX_FIRST_CYCLES(20), .PAUSE_UNIT_CYCLES(PU), .LIGHT_PERIOD_CYCLES(50)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe(sda_oe), .prox_sample(prox_sample), .light_sample(light_sample),
    .led_sink_output(led), .led_sink_strength(strength), .light_sense_on(light_on),
    .light_span_select(span), .light_spectrum_select(spectrum), .event_n_o(),
    .event_n_oe(ev_oe));
  lps_bus_master bus_u (.scl(scl), .sda_low(sda_low), .sda(sda));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic lps_byte_t rst_val(input int a);
    case (a)
      4, 7: return 8'hFF;
      6: return 8'hF0;
      default: return 8'h00;
    endcase
  endfunction : rst_val
  function automatic int pause_cyc(input logic [2:0] f);
    case (f)
      3'h7: return 0;
      3'h6: return PU;
      3'h5: return 4 * PU;
      3'h4: return 6 * PU;
      3'h3: return 8 * PU;
      3'h2: return 16 * PU;
      3'h1: return 32 * PU;
      default: return 64 * PU;
    endcase
  endfunction : pause_cyc
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_near(input string n, input int e, input int g);
    cmp_count++;
    if (g < e - 2 || g > e + 2)
    begin
      miscompares++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_near
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : tick
  task automatic wr(input lps_byte_t p, input lps_byte_t q[$]);
    logic a;
    bus_u.start();
    bus_u.wbyte(8'h88, a);
    chk("write target ack", 1'b1, a);
    bus_u.wbyte(p, a);
    foreach (q[i]) bus_u.wbyte(q[i], a);
    bus_u.stop();
  endtask : wr
  task automatic rdn(input lps_byte_t p, input int n);
    logic      a;
    lps_byte_t d;
    rd = {};
    bus_u.start();
    bus_u.wbyte(8'h88, a);
    bus_u.wbyte(p, a);
    bus_u.start();
    bus_u.wbyte(8'h89, a);
    chk("read target ack", 1'b1, a);
    for (int i = 0; i < n; i++)
    begin
      bus_u.rbyte(i == n - 1, d);
      rd.push_back(d);
    end
    bus_u.stop();
  endtask : rdn
  // Skips the pulse in progress and the pause after it, then measures the next whole pulse and the pause after it.
  task automatic led_times(output int hi, output int lo);
    for (hi = 0; led === 1'b1 && hi < 100; hi++) tick(1);
    for (lo = 0; led !== 1'b1 && lo < 3000; lo++) tick(1);
    for (hi = 0; led === 1'b1 && hi < 100; hi++) tick(1);
    for (lo = 0; led !== 1'b1 && lo < 3000; lo++) tick(1);
  endtask : led_times
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end
  initial
  begin
    lps_byte_t v[$];
    lps_byte_t s;
    logic      a;
    int        hi, lo;
    tick(2);
    reset = 1'b0;
    tick(10);
    rdn(8'h00, 16);
    foreach (rd[i]) chk($sformatf("reset value %0h", i), rst_val(i), rd[i]);
    s = lps_byte_t'(rnd());
    if (s[7:1] == 7'h44) s[7:1] = 7'h45;
    bus_u.start();
    bus_u.wbyte(s, a);
    bus_u.stop();
    chk("foreign address ack", 1'b0, a);
    repeat (6) v.push_back(lps_byte_t'(rnd()));
    wr(8'h03, v);
    rdn(8'h03, 6);
    v[5] = 8'h00;
    foreach (rd[i]) chk("threshold readback", v[i], rd[i]);
    wr(8'h0E, '{8'h00, 8'h00});
    repeat (4)
    begin
      s = lps_byte_t'(rnd()) & 8'h0F;
      wr(8'h01, '{s});
      tick(2);
      chk("sink strength", s[3], strength);
      chk("light on", s[2], light_on);
      chk("span select", s[1], span);
      chk("spectrum select", s[0], spectrum);
      rdn(8'h01, 1);
      chk("setup readback", s, rd[0]);
    end
    prox_sample = lps_byte_t'(rnd()) | 8'h80;
    light_sample = lps_word12_t'(rnd());
    for (int f = 0; f < 8; f++)
    begin
      wr(8'h01, '{{1'b1, f[2:0], 4'h4}});
      led_times(hi, lo);
      if (f != 7) chk_near("led pulse", 20, hi);
      chk_near("led pause", pause_cyc(f[2:0]), lo);
    end
    tick(60);
    rdn(8'h08, 3);
    chk("proximity result", prox_sample, rd[0]);
    chk("light result low", light_sample[7:0], rd[1]);
    chk("light result high", {4'h0, light_sample[11:8]}, rd[2]);
    wr(8'h03, '{8'h00, 8'h10, 8'h00, 8'hF0, 8'hFF});
    wr(8'h02, '{8'h01});
    tick(60);
    chk("event pin and", 1'b0, ev_oe);
    rdn(8'h02, 1);
    chk("event flags", 8'h81, rd[0]);
    wr(8'h02, '{8'h00});
    tick(60);
    chk("event pin or", 1'b1, ev_oe);
    // Quiet samples empty the trip count, then sixteen trips in a row are needed.
    prox_sample = 8'h00;
    wr(8'h02, '{8'h60});
    tick(1);
    prox_sample = 8'hFF;
    tick(200);
    chk("persist early", 1'b0, ev_oe);
    tick(200);
    chk("persist met", 1'b1, ev_oe);
    wr(8'h01, '{8'h00});
    tick(60);
    wr(8'h02, '{8'h80});
    rdn(8'h02, 1);
    chk("flag kept", 8'h80, rd[0]);
    wr(8'h02, '{8'h00});
    tick(4);
    chk("event pin idle", 1'b0, ev_oe);
    rdn(8'h02, 1);
    chk("flag cleared", 8'h00, rd[0]);
    finish_test();
  end
endmodule : test_lps_regs
`default_nettype wire
